// ===== oam_remote_command_fields.sv
/*
  Upper payload bytes of an outgoing maintenance frame and the sent-frame
  counter.
  Assumes a single-cycle register port, a remote-command strobe from the
  send-command logic, and a frame serializer that latches the payload
  bytes at frame start and pulses frameSent per valid frame.
*/
// Functional notes
// - On a remote command, payload byte five is the address register.
// - On a remote command, payload byte six comes from the data register.
// - In extended mode the address register holds the target address.
// - In extended mode the data register holds the remote command data byte.
// - Each valid maintenance frame sent increments the sent counter until it reaches 255, except one sent in the same cycle as a clear.
// - The sent counter reads as the binary number of frames sent, 0 to 255.
// - Writing zero to the send-command register clears the sent counter.
// - Mode 00 is normal, 10 is extended, 01 and 11 are reserved.
// - Code 00 read reply, 01 read request, 10 write reply, 11 write request.
`timescale 1ns/10ps
module oam_remote_command_fields
  import oam_fields_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [DATA_W-1:0]     regRdata,
  input  wire logic                  remoteCmd,
  input  wire logic                  frameSent,
  output payload_hi_type             payloadHi,
  output logic                       extendedMode,
  output op_code_type                opCode
);

  reg_req_type    req;
  logic [7:0]     cmdMode_q;
  logic [7:0]     cmdMode_d;
  logic [7:0]     cmdAddress_q;
  logic [7:0]     cmdAddress_d;
  logic [7:0]     cmdData_q;
  logic [7:0]     cmdData_d;
  logic [7:0]     modelLo_q;
  logic [7:0]     modelLo_d;
  logic [7:0]     modelHi_q;
  logic [7:0]     modelHi_d;
  logic [7:0]     rdata_q;
  logic [7:0]     rdata_d;
  payload_hi_type payload_q;
  payload_hi_type payload_d;
  logic [7:0]     sentCount;
  logic           clearCount;
  op_mode_type    opMode;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Mode byte carries the mode and code fields read by the far end
  assign opMode = op_mode_type'(cmdMode_q[MODE_LSB +: 2]);
  assign opCode = op_code_type'(cmdMode_q[CODE_LSB +: 2]);

  // Clear fires on the send-command write itself; the command register
  // lives elsewhere, only the zero value matters here
  assign clearCount = req.wr && req.addr == OFF_SEND_CMD
                      && req.wdata == SEND_CLEAR_VAL;

  always_comb begin
    cmdMode_d    = cmdMode_q;
    cmdAddress_d = cmdAddress_q;
    cmdData_d    = cmdData_q;
    modelLo_d    = modelLo_q;
    modelHi_d    = modelHi_q;
    if (req.wr) begin
      case (req.addr)
        OFF_CMD_MODE: begin
          cmdMode_d = (req.wdata & MODE_RW_MASK) | MODE_RO_BITS;
        end
        OFF_CMD_ADDRESS: begin
          cmdAddress_d = req.wdata;
        end
        OFF_CMD_DATA: begin
          cmdData_d = req.wdata;
        end
        OFF_MODEL_LO: begin
          modelLo_d = req.wdata;
        end
        OFF_MODEL_HI: begin
          modelHi_d = req.wdata;
        end
        default: begin
          // Counter and unmapped offsets ignore writes
          cmdMode_d = cmdMode_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmdMode_q    <= RST_CMD_MODE;
      cmdAddress_q <= RST_CMD_ADDRESS;
      cmdData_q    <= RST_CMD_DATA;
      modelLo_q    <= RST_MODEL;
      modelHi_q    <= RST_MODEL;
    end else begin
      cmdMode_q    <= cmdMode_d;
      cmdAddress_q <= cmdAddress_d;
      cmdData_q    <= cmdData_d;
      modelLo_q    <= modelLo_d;
      modelHi_q    <= modelHi_d;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        OFF_CMD_MODE:    rdata_d = cmdMode_q;
        OFF_CMD_ADDRESS: rdata_d = cmdAddress_q;
        OFF_CMD_DATA:    rdata_d = cmdData_q;
        OFF_SENT_COUNT:  rdata_d = sentCount;
        OFF_MODEL_LO:    rdata_d = modelLo_q;
        OFF_MODEL_HI:    rdata_d = modelHi_q;
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // Payload is selected combinationally from the strobe and then registered, so the serializer
  // sees the remote bytes one cycle after the cycle it registers the command
  always_comb begin
    if (remoteCmd) begin
      payload_d.byteFive = cmdAddress_q;
      payload_d.byteSix  = cmdData_q;
    end else begin
      payload_d.byteFive = modelLo_q;
      payload_d.byteSix  = modelHi_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_q   <= 8'h00;
      payload_q <= '0;
    end else begin
      rdata_q   <= rdata_d;
      payload_q <= payload_d;
    end
  end

  assign regRdata     = rdata_q;
  assign payloadHi    = payload_q;
  assign extendedMode = (opMode == MODE_EXTENDED);

  sent_counter u_sent_counter (
    .mclk       (mclk),
    .rstn       (rstn),
    .frameSent  (frameSent),
    .clearCount (clearCount),
    .count      (sentCount)
  );

  sequence s_remote_issued;
    remoteCmd && !(req.wr && (req.addr == OFF_CMD_ADDRESS
                              || req.addr == OFF_CMD_DATA));
  endsequence

  property p_byte_five;
    @(posedge mclk) disable iff (!rstn)
      s_remote_issued |=> payloadHi.byteFive == $past(cmdAddress_q);
  endproperty
  a_byte_five: assert property (p_byte_five)
    else $error("byte five not from address register");

  property p_byte_six;
    @(posedge mclk) disable iff (!rstn)
      s_remote_issued |=> payloadHi.byteSix == $past(cmdData_q);
  endproperty
  a_byte_six: assert property (p_byte_six)
    else $error("byte six not from data register");

  property p_normal_bytes;
    @(posedge mclk) disable iff (!rstn)
      !remoteCmd |=> payloadHi.byteFive == $past(modelLo_q)
                     && payloadHi.byteSix == $past(modelHi_q);
  endproperty
  a_normal_bytes: assert property (p_normal_bytes)
    else $error("normal payload not from model bytes");

  property p_addr_store;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_CMD_ADDRESS)
        |=> cmdAddress_q == $past(regWdata);
  endproperty
  a_addr_store: assert property (p_addr_store)
    else $error("address byte not stored");

  property p_data_store;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_CMD_DATA) |=> cmdData_q == $past(regWdata);
  endproperty
  a_data_store: assert property (p_data_store)
    else $error("data byte not stored");

  property p_code_read;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_CMD_MODE)
        |=> opCode == op_code_type'($past(regWdata[CODE_LSB +: 2]));
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("operating code not taken");

  property p_count_read;
    @(posedge mclk) disable iff (!rstn)
      (req.rd && req.addr == OFF_SENT_COUNT) |=> regRdata == $past(sentCount);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("counter readback wrong");

  sequence s_count_clear;
    clearCount;
  endsequence

  // Read of the counter with nothing else moving it in that cycle
  sequence s_quiet_count_read;
    req.rd && req.addr == OFF_SENT_COUNT && !frameSent && !clearCount;
  endsequence

  property p_clear_read;
    @(posedge mclk) disable iff (!rstn)
      s_count_clear ##1 s_quiet_count_read |=> regRdata == RST_SENT_COUNT;
  endproperty
  a_clear_read: assert property (p_clear_read)
    else $error("counter not zero after clear");

  property p_addr_hold;
    @(posedge mclk) disable iff (!rstn)
      !(req.wr && req.addr == OFF_CMD_ADDRESS) |=> $stable(cmdAddress_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address byte changed without a write");

  property p_data_hold;
    @(posedge mclk) disable iff (!rstn)
      !(req.wr && req.addr == OFF_CMD_DATA) |=> $stable(cmdData_q);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data byte changed without a write");

  property p_addr_read;
    @(posedge mclk) disable iff (!rstn)
      (req.rd && req.addr == OFF_CMD_ADDRESS)
        |=> regRdata == $past(cmdAddress_q);
  endproperty
  a_addr_read: assert property (p_addr_read)
    else $error("address byte readback wrong");

  property p_data_read;
    @(posedge mclk) disable iff (!rstn)
      (req.rd && req.addr == OFF_CMD_DATA)
        |=> regRdata == $past(cmdData_q);
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data byte readback wrong");

  property p_mode_decode;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_CMD_MODE)
        |=> extendedMode == ($past(regWdata[MODE_LSB +: 2]) == MODE_EXTENDED);
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("extended mode flag wrong after mode write");

  // Capability bits are not writable; the far end relies on them
  property p_mode_fixed;
    @(posedge mclk) disable iff (!rstn)
      (cmdMode_q & ~MODE_RW_MASK) == MODE_RO_BITS;
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("read-only mode bits changed");

  property p_rdata_idle;
    @(posedge mclk) disable iff (!rstn)
      !req.rd |=> regRdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared after read cycle");

  property p_count_ro;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_SENT_COUNT && !frameSent)
        |=> $stable(sentCount);
  endproperty
  a_count_ro: assert property (p_count_ro)
    else $error("counter took a software write");

  property p_clear_zero_only;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_SEND_CMD && req.wdata != SEND_CLEAR_VAL
       && !frameSent) |=> $stable(sentCount);
  endproperty
  a_clear_zero_only: assert property (p_clear_zero_only)
    else $error("counter cleared by a nonzero command");

  property p_model_lo_store;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_MODEL_LO) |=> modelLo_q == $past(regWdata);
  endproperty
  a_model_lo_store: assert property (p_model_lo_store)
    else $error("low model byte not stored");

  property p_model_hi_store;
    @(posedge mclk) disable iff (!rstn)
      (req.wr && req.addr == OFF_MODEL_HI) |=> modelHi_q == $past(regWdata);
  endproperty
  a_model_hi_store: assert property (p_model_hi_store)
    else $error("high model byte not stored");

endmodule : oam_remote_command_fields

// ===== oam_fields_pkg.sv
/*
  Package for the maintenance-frame remote command field block:
  register offsets, reset values, mode and code encodings, carriers.
  Assumes an 8-bit register port and one 100 MHz clock.
*/
package oam_fields_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;

  localparam logic [7:0]  OFF_CMD_MODE    = 8'h4a;
  localparam logic [7:0]  OFF_CMD_ADDRESS = 8'h4b;
  localparam logic [7:0]  OFF_CMD_DATA    = 8'h4c;
  localparam logic [7:0]  OFF_SENT_COUNT  = 8'h4d;
  localparam logic [7:0]  OFF_SEND_CMD    = 8'h44;
  localparam logic [7:0]  OFF_MODEL_LO    = 8'h56;
  localparam logic [7:0]  OFF_MODEL_HI    = 8'h57;

  localparam logic [7:0]  RST_CMD_MODE    = 8'h22;
  localparam logic [7:0]  RST_CMD_ADDRESS = 8'h00;
  localparam logic [7:0]  RST_CMD_DATA    = 8'h00;
  localparam logic [7:0]  RST_SENT_COUNT  = 8'h00;
  localparam logic [7:0]  RST_MODEL       = 8'h00;
  localparam logic [7:0]  SEND_CLEAR_VAL  = 8'h00;
  localparam logic [7:0]  COUNT_MAX       = 8'hff;

  localparam int          MODE_LSB        = 0;
  localparam int          CODE_LSB        = 2;
  localparam logic [7:0]  MODE_RW_MASK    = 8'hcf;
  localparam logic [7:0]  MODE_RO_BITS    = 8'h20;

  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_RSVD_01  = 2'b01,
    MODE_EXTENDED = 2'b10,
    MODE_RSVD_11  = 2'b11
  } op_mode_type;

  typedef enum logic [1:0] {
    CODE_READ_REPLY   = 2'b00,
    CODE_READ_REQUEST = 2'b01,
    CODE_WRITE_REPLY  = 2'b10,
    CODE_WRITE_REQUEST = 2'b11
  } op_code_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] byteSix;
    logic [7:0] byteFive;
  } payload_hi_type;

endpackage : oam_fields_pkg

// ===== sent_counter.sv
/*
  Saturating count of valid maintenance frames sent.
  Assumes a one-cycle sent pulse from the serializer and a clear strobe.
*/
`timescale 1ns/10ps
module sent_counter
  import oam_fields_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       frameSent,
  input  wire logic       clearCount,
  output logic [7:0]      count
);

  logic [7:0] count_q;
  logic [7:0] count_d;

  always_comb begin
    count_d = count_q;
    if (clearCount) begin
      count_d = RST_SENT_COUNT;
    end else if (frameSent && count_q != COUNT_MAX) begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      count_q <= RST_SENT_COUNT;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

  property p_count_hold;
    @(posedge mclk) disable iff (!rstn)
      (count_q == COUNT_MAX && !clearCount) |=> count_q == COUNT_MAX;
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("counter wrapped past full");

  property p_count_step;
    @(posedge mclk) disable iff (!rstn)
      (frameSent && !clearCount && count_q != COUNT_MAX)
        |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter missed a sent frame");

  property p_count_idle;
    @(posedge mclk) disable iff (!rstn)
      (!frameSent && !clearCount) |=> $stable(count_q);
  endproperty
  a_count_idle: assert property (p_count_idle)
    else $error("counter moved without a frame");

  property p_count_clear;
    @(posedge mclk) disable iff (!rstn)
      clearCount |=> count_q == RST_SENT_COUNT;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("counter not cleared");

endmodule : sent_counter

// ===== serializer_model.sv
/*
  Behavioural frame serializer that sits beside the remote command field
  block: selects the remote bytes, latches the payload, reports frames.
  Assumes the block's mclk, rstn and registered payloadHi output.
*/
`timescale 1ns/10ps
module serializer_model
  import oam_fields_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  wire logic           sendReq,
  input  wire logic           useRemote,
  input  wire payload_hi_type payloadHi,
  output logic                remoteCmd,
  output logic                frameSent,
  output payload_hi_type      latched
);
  logic [1:0] stepQ;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stepQ     <= 2'h0;
      remoteCmd <= 1'b0;
      frameSent <= 1'b0;
      latched   <= '0;
    end else begin
      frameSent <= 1'b0;
      case (stepQ)
        2'h0: if (sendReq) begin
          remoteCmd <= useRemote;
          stepQ     <= 2'h1;
        end
        2'h1: stepQ <= 2'h2;
        2'h2: begin
          // Payload is registered, so it is taken a cycle after the select
          latched   <= payloadHi;
          frameSent <= 1'b1;
          remoteCmd <= 1'b0;
          stepQ     <= 2'h3;
        end
        default: stepQ <= 2'h0;
      endcase
    end
  end
endmodule : serializer_model

// ===== testbench.sv
/*
  Self-checking bench for the remote command field block and its counter.
  Assumes the serializer model and the package constants.
*/
`timescale 1ns/10ps
module testbench;
  import oam_fields_pkg::*;
  logic           mclk = 1'b0;
  logic           rstn = 1'b0;
  logic [7:0]     regAddr = 8'h00;
  logic [7:0]     regWdata = 8'h00;
  logic           regWr = 1'b0;
  logic           regRd = 1'b0;
  logic [7:0]     regRdata;
  logic           sendReq = 1'b0;
  logic           useRemote = 1'b0;
  logic           remoteCmd;
  logic           frameSent;
  logic           extendedMode;
  op_code_type    opCode;
  payload_hi_type payloadHi;
  payload_hi_type latched;
  int             errors = 0;
  int             checksDone = 0;

  always #5 mclk = ~mclk;

  oam_remote_command_fields oam_remote_command_fields_inst (
    .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .remoteCmd(remoteCmd), .frameSent(frameSent), .payloadHi(payloadHi),
    .extendedMode(extendedMode), .opCode(opCode));

  serializer_model serializer_model_inst (
    .mclk(mclk), .rstn(rstn), .sendReq(sendReq), .useRemote(useRemote),
    .payloadHi(payloadHi), .remoteCmd(remoteCmd), .frameSent(frameSent),
    .latched(latched));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk({8'h00, regRdata}, {8'h00, exp});
  endtask : rd

  task automatic frame(input logic remote);
    @(posedge mclk);
    sendReq   <= 1'b1;
    useRemote <= remote;
    @(posedge mclk);
    sendReq <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : frame

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rd(OFF_CMD_ADDRESS, 8'h00);
    rd(OFF_CMD_DATA, 8'h00);
    rd(OFF_SENT_COUNT, 8'h00);
    rd(OFF_CMD_MODE, 8'h22);
    chk({15'h0, extendedMode}, 16'h0001);
    $display("Test reset values finished");
    wr(OFF_CMD_ADDRESS, 8'ha5);
    wr(OFF_CMD_DATA, 8'h3c);
    wr(OFF_MODEL_LO, 8'h11);
    wr(OFF_MODEL_HI, 8'h96);
    rd(OFF_CMD_ADDRESS, 8'ha5);
    rd(OFF_CMD_DATA, 8'h3c);
    frame(1'b0);
    chk(latched, 16'h9611);
    frame(1'b1);
    chk(latched, 16'h3ca5);
    frame(1'b0);
    chk(latched, 16'h9611);
    rd(OFF_SENT_COUNT, 8'h03);
    $display("Test payload select finished");
    wr(OFF_SENT_COUNT, 8'h55);
    rd(OFF_SENT_COUNT, 8'h03);
    rd(8'h60, 8'h00);
    wr(OFF_SEND_CMD, 8'h01);
    rd(OFF_SENT_COUNT, 8'h03);
    wr(OFF_SEND_CMD, 8'h00);
    rd(OFF_SENT_COUNT, 8'h00);
    $display("Test counter access finished");
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        wr(OFF_CMD_MODE, {4'h0, c[1:0], m[1:0]});
        #1;
        chk({15'h0, extendedMode}, {15'h0, m == 2});
        chk({14'h0, opCode}, {14'h0, c[1:0]});
      end
    end
    wr(OFF_CMD_MODE, 8'hff);
    rd(OFF_CMD_MODE, 8'hef);
    $display("Test modes and codes finished");
    for (int i = 0; i < 255; i++) begin
      frame(i[0]);
    end
    rd(OFF_SENT_COUNT, 8'hff);
    frame(1'b1);
    rd(OFF_SENT_COUNT, 8'hff);
    // Clear and read back to back, so the read sees the first cleared cycle
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= OFF_SEND_CMD;
    regWdata <= SEND_CLEAR_VAL;
    @(posedge mclk);
    regWr   <= 1'b0;
    regRd   <= 1'b1;
    regAddr <= OFF_SENT_COUNT;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk({8'h00, regRdata}, {8'h00, RST_SENT_COUNT});
    $display("Test saturation finished");
    wrap_up();
  end
endmodule : testbench
